// *** design/psm_pkg.sv ***
// Constants, positions and types shared by the serial management slave
package psm_pkg;

  // ----------------------------------------------------------------
  // Timing
  // ----------------------------------------------------------------
  localparam int CLK_PERIOD_NS = 20;
  localparam int MDC_MAX_RATE_KHZ = 12500;
  localparam int MDC_MIN_PERIOD_NS = 1000000 / MDC_MAX_RATE_KHZ;
  localparam int MDC_MIN_PERIOD_CYC = MDC_MIN_PERIOD_NS / CLK_PERIOD_NS;
  localparam int SYNC_MIN_CYC = 4;

  // ----------------------------------------------------------------
  // Frame bit positions, counted from the first start bit
  // ----------------------------------------------------------------
  localparam logic [4:0] POS_START2 = 5'h01;
  localparam logic [4:0] POS_OP_LAST = 5'h03;
  localparam logic [4:0] POS_HDR_LAST = 5'h0D;
  localparam logic [4:0] POS_TA1 = 5'h0E;
  localparam logic [4:0] POS_TA2 = 5'h0F;
  localparam logic [4:0] POS_LAST = 5'h1F;

  // ----------------------------------------------------------------
  // Opcodes and header layout
  // ----------------------------------------------------------------
  localparam logic [1:0] OP_READ = 2'h2;
  localparam logic [1:0] OP_WRITE = 2'h1;
  localparam int HDR_OP_LSB = 10;
  localparam int HDR_PHY_LSB = 5;
  localparam int HDR_REG_LSB = 0;

  // ----------------------------------------------------------------
  // Register indices and fields
  // ----------------------------------------------------------------
  localparam logic [4:0] REG_EXT_CTRL = 5'h0D;
  localparam logic [4:0] REG_EXT_DATA = 5'h0E;
  localparam logic [4:0] REG_INT_MASK = 5'h19;
  localparam logic [4:0] REG_INT_STAT = 5'h1A;
  localparam logic [4:0] REG_PAGE = 5'h1F;
  localparam int INT_PIN_EN_BIT = 15;
  localparam int INT_EVENT_BIT = 15;
  localparam int EXT_FUNC_LSB = 14;
  localparam logic [1:0] EXT_FUNC_ADDR = 2'h0;
  localparam logic [15:0] REG_RESET = 16'h0000;
  localparam logic [4:0] PHY_ADDR_RESET = 5'h00;

  // ----------------------------------------------------------------
  // Frame state machine
  // ----------------------------------------------------------------
  typedef enum logic [6:0] {
    S_IDLE  = 7'h01,
    S_PRE   = 7'h02,
    S_START = 7'h04,
    S_HDR   = 7'h08,
    S_TURN  = 7'h10,
    S_DATA  = 7'h20,
    S_SKIP  = 7'h40
  } psm_state_t;

endpackage : psm_pkg

// *** design/psm_reg_if.sv ***
// Register access carrier between frame logic and register bank
`timescale 1ns/1ps
interface psm_reg_if;
  logic rd;
  logic wr;
  logic [4:0] addr;
  logic [15:0] wdata;
  logic [15:0] rdata;

  modport frame (output rd, output wr, output addr, output wdata, input rdata);
  modport bank (input rd, input wr, input addr, input wdata, output rdata);
endinterface : psm_reg_if

// *** design/psm_reg_bank.sv ***
// Paged register bank with indirect extended space and interrupt status
`timescale 1ns/1ps
module psm_reg_bank #(
  parameter int PAGES = 2,
  parameter int EXT_DEPTH = 8
) (
  input wire logic clk,
  input wire logic rst_n,
  psm_reg_if.bank bus,
  input wire logic i_int_event,
  output logic o_int_pending
);

  localparam int PAGE_W = (PAGES > 1) ? $clog2(PAGES) : 1;
  localparam int EXT_W = (EXT_DEPTH > 1) ? $clog2(EXT_DEPTH) : 1;

  // ----------------------------------------------------------------
  // Parameter check
  // ----------------------------------------------------------------
  if (PAGES < 1 || PAGES > 256 || EXT_DEPTH < 1 || EXT_DEPTH > 65536) begin : g_chk
    $error("psm_reg_bank: unsupported PAGES or EXT_DEPTH");
  end

  logic [15:0] page_r;
  logic [15:0] ext_ctrl_r;
  logic [15:0] ext_addr_r;
  logic [15:0] int_mask_r;
  logic [15:0] int_stat_r;
  logic [15:0] int_stat_nxt;
  logic [15:0] page_mem [PAGES][32];
  logic [15:0] ext_mem [EXT_DEPTH];
  logic page_ok;
  logic ext_ok;
  logic ext_is_data;
  logic special;
  logic [PAGE_W-1:0] page_idx;
  logic [EXT_W-1:0] ext_idx;

  assign page_ok = (32'(page_r) < PAGES);
  assign page_idx = page_r[PAGE_W-1:0];
  assign ext_ok = (32'(ext_addr_r) < EXT_DEPTH);
  assign ext_idx = ext_addr_r[EXT_W-1:0];
  assign ext_is_data = (ext_ctrl_r[psm_pkg::EXT_FUNC_LSB+1:psm_pkg::EXT_FUNC_LSB] != psm_pkg::EXT_FUNC_ADDR);
  assign special = (bus.addr == psm_pkg::REG_EXT_CTRL) || (bus.addr == psm_pkg::REG_EXT_DATA) ||
                   (bus.addr == psm_pkg::REG_INT_MASK) || (bus.addr == psm_pkg::REG_INT_STAT) ||
                   (bus.addr == psm_pkg::REG_PAGE);

  // ----------------------------------------------------------------
  // Paged general registers
  // ----------------------------------------------------------------
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      for (int p = 0; p < PAGES; p++) begin
        for (int r = 0; r < 32; r++) begin
          page_mem[p][r] <= psm_pkg::REG_RESET;
        end
      end
    end else if (bus.wr && !special && page_ok) begin
      page_mem[page_idx][bus.addr] <= bus.wdata;
    end
  end

  // ----------------------------------------------------------------
  // Page select, indirect extended space and interrupt mask
  // ----------------------------------------------------------------
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      page_r <= psm_pkg::REG_RESET;
      ext_ctrl_r <= psm_pkg::REG_RESET;
      ext_addr_r <= psm_pkg::REG_RESET;
      int_mask_r <= psm_pkg::REG_RESET;
    end else if (bus.wr) begin
      if (bus.addr == psm_pkg::REG_PAGE) begin
        page_r <= bus.wdata;
      end
      if (bus.addr == psm_pkg::REG_EXT_CTRL) begin
        ext_ctrl_r <= bus.wdata;
      end
      if (bus.addr == psm_pkg::REG_EXT_DATA && !ext_is_data) begin
        ext_addr_r <= bus.wdata;
      end
      if (bus.addr == psm_pkg::REG_INT_MASK) begin
        int_mask_r <= bus.wdata;
      end
    end
  end

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      for (int e = 0; e < EXT_DEPTH; e++) begin
        ext_mem[e] <= psm_pkg::REG_RESET;
      end
    end else if (bus.wr && bus.addr == psm_pkg::REG_EXT_DATA && ext_is_data && ext_ok) begin
      ext_mem[ext_idx] <= bus.wdata;
    end
  end

  // ----------------------------------------------------------------
  // Interrupt status, cleared by read, event wins
  // ----------------------------------------------------------------
  always_comb begin
    int_stat_nxt = int_stat_r;
    if (bus.rd && bus.addr == psm_pkg::REG_INT_STAT) begin
      int_stat_nxt = psm_pkg::REG_RESET;
    end
    if (i_int_event) begin
      int_stat_nxt[psm_pkg::INT_EVENT_BIT] = 1'b1;
    end
  end

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      int_stat_r <= psm_pkg::REG_RESET;
    end else begin
      int_stat_r <= int_stat_nxt;
    end
  end

  assign o_int_pending = int_mask_r[psm_pkg::INT_PIN_EN_BIT] && (int_stat_r != psm_pkg::REG_RESET);

  // ----------------------------------------------------------------
  // Read multiplexer
  // ----------------------------------------------------------------
  always_comb begin
    unique case (bus.addr)
      psm_pkg::REG_PAGE: bus.rdata = page_r;
      psm_pkg::REG_EXT_CTRL: bus.rdata = ext_ctrl_r;
      psm_pkg::REG_EXT_DATA: bus.rdata = !ext_is_data ? ext_addr_r :
                                         (ext_ok ? ext_mem[ext_idx] : psm_pkg::REG_RESET);
      psm_pkg::REG_INT_MASK: bus.rdata = int_mask_r;
      psm_pkg::REG_INT_STAT: bus.rdata = int_stat_r;
      default: bus.rdata = page_ok ? page_mem[page_idx][bus.addr] : psm_pkg::REG_RESET;
    endcase
  end

endmodule : psm_reg_bank

// *** design/psm_mgmt_slave.sv ***
// Serial management slave: frame decoder, read driver and interrupt pin
`timescale 1ns/1ps
module psm_mgmt_slave #(
  parameter int PAGES = 2,
  parameter int EXT_DEPTH = 8
) (
  input wire logic I_CLK,
  input wire logic I_RESETN,
  input wire logic I_MDC,
  input wire logic I_MDIO,
  output logic O_MDIO,
  output logic O_MDIO_OE,
  input wire logic [4:0] I_PHY_ADDR,
  input wire logic I_INT_EVENT,
  output logic O_MGMT_INTERRUPT_N,
  output logic O_MGMT_INTERRUPT_N_OE
);

  // ----------------------------------------------------------------
  // Parameter check
  // ----------------------------------------------------------------
  if (psm_pkg::MDC_MIN_PERIOD_CYC < psm_pkg::SYNC_MIN_CYC) begin : g_chk
    $error("psm_mgmt_slave: clock too slow for fastest management clock");
  end

  psm_reg_if reg_bus ();

  // ----------------------------------------------------------------
  // Pin synchronisers
  // ----------------------------------------------------------------
  logic mdc_s1_r;
  logic mdc_s2_r;
  logic mdc_s3_r;
  logic mdio_s1_r;
  logic mdio_s2_r;
  logic [4:0] phy_s1_r;
  logic [4:0] phy_s2_r;

  always_ff @(posedge I_CLK or negedge I_RESETN) begin
    if (!I_RESETN) begin
      mdc_s1_r <= 1'b0;
      mdc_s2_r <= 1'b0;
      mdc_s3_r <= 1'b0;
      mdio_s1_r <= 1'b1;
      mdio_s2_r <= 1'b1;
    end else begin
      mdc_s1_r <= I_MDC;
      mdc_s2_r <= mdc_s1_r;
      mdc_s3_r <= mdc_s2_r;
      mdio_s1_r <= I_MDIO;
      mdio_s2_r <= mdio_s1_r;
    end
  end

  for (genvar b = 0; b < 5; b++) begin : g_phy_sync
    always_ff @(posedge I_CLK or negedge I_RESETN) begin
      if (!I_RESETN) begin
        phy_s1_r[b] <= psm_pkg::PHY_ADDR_RESET[b];
        phy_s2_r[b] <= psm_pkg::PHY_ADDR_RESET[b];
      end else begin
        phy_s1_r[b] <= I_PHY_ADDR[b];
        phy_s2_r[b] <= phy_s1_r[b];
      end
    end
  end

  logic bit_stb;
  logic bit_in;

  assign bit_stb = mdc_s2_r && !mdc_s3_r;
  assign bit_in = mdio_s2_r;

  // ----------------------------------------------------------------
  // Frame state machine
  // ----------------------------------------------------------------
  psm_pkg::psm_state_t state_r;
  psm_pkg::psm_state_t state_nxt;
  logic [4:0] pos_r;
  logic [11:0] hdr_r;
  logic [11:0] hdr_full;
  logic [15:0] wsh_r;
  logic [4:0] reg_addr_r;
  logic read_r;
  logic write_r;
  logic op_ok;
  logic addr_match;
  logic hdr_is_read;
  logic hdr_is_write;

  assign hdr_full = {hdr_r[10:0], bit_in};
  assign op_ok = ({hdr_r[0], bit_in} == psm_pkg::OP_READ) || ({hdr_r[0], bit_in} == psm_pkg::OP_WRITE);
  assign addr_match = (hdr_full[psm_pkg::HDR_PHY_LSB +: 5] == phy_s2_r);
  assign hdr_is_read = (hdr_full[psm_pkg::HDR_OP_LSB +: 2] == psm_pkg::OP_READ);
  assign hdr_is_write = (hdr_full[psm_pkg::HDR_OP_LSB +: 2] == psm_pkg::OP_WRITE);

  always_comb begin
    state_nxt = state_r;
    if (bit_stb) begin
      unique case (state_r)
        psm_pkg::S_IDLE: begin
          if (bit_in) begin
            state_nxt = psm_pkg::S_PRE;
          end
        end
        psm_pkg::S_PRE: begin
          if (!bit_in) begin
            state_nxt = psm_pkg::S_START;
          end
        end
        psm_pkg::S_START: begin
          state_nxt = bit_in ? psm_pkg::S_HDR : psm_pkg::S_SKIP;
        end
        psm_pkg::S_HDR: begin
          if (pos_r == psm_pkg::POS_OP_LAST && !op_ok) begin
            state_nxt = psm_pkg::S_SKIP;
          end else if (pos_r == psm_pkg::POS_HDR_LAST) begin
            state_nxt = psm_pkg::S_TURN;
          end
        end
        psm_pkg::S_TURN: begin
          if (pos_r == psm_pkg::POS_TA2) begin
            state_nxt = psm_pkg::S_DATA;
          end
        end
        psm_pkg::S_DATA, psm_pkg::S_SKIP: begin
          if (pos_r == psm_pkg::POS_LAST) begin
            state_nxt = psm_pkg::S_PRE;
          end
        end
        default: state_nxt = psm_pkg::S_IDLE;
      endcase
    end
  end

  always_ff @(posedge I_CLK or negedge I_RESETN) begin
    if (!I_RESETN) begin
      state_r <= psm_pkg::S_IDLE;
    end else begin
      state_r <= state_nxt;
    end
  end

  // Bit position within the 32-bit frame
  always_ff @(posedge I_CLK or negedge I_RESETN) begin
    if (!I_RESETN) begin
      pos_r <= 5'h00;
    end else if (bit_stb) begin
      if (state_r == psm_pkg::S_IDLE || state_r == psm_pkg::S_PRE) begin
        pos_r <= psm_pkg::POS_START2;
      end else begin
        pos_r <= pos_r + 5'h01;
      end
    end
  end

  // ----------------------------------------------------------------
  // Header and write data capture
  // ----------------------------------------------------------------
  always_ff @(posedge I_CLK or negedge I_RESETN) begin
    if (!I_RESETN) begin
      hdr_r <= 12'h000;
      wsh_r <= 16'h0000;
    end else if (bit_stb) begin
      if (state_r == psm_pkg::S_HDR) begin
        hdr_r <= hdr_full;
      end
      if (state_r == psm_pkg::S_DATA) begin
        wsh_r <= {wsh_r[14:0], bit_in};
      end
    end
  end

  always_ff @(posedge I_CLK or negedge I_RESETN) begin
    if (!I_RESETN) begin
      reg_addr_r <= 5'h00;
    end else if (bit_stb && state_r == psm_pkg::S_HDR && pos_r == psm_pkg::POS_HDR_LAST) begin
      reg_addr_r <= hdr_full[psm_pkg::HDR_REG_LSB +: 5];
    end
  end

  // Read or write granted only to a matching address
  always_ff @(posedge I_CLK or negedge I_RESETN) begin
    if (!I_RESETN) begin
      read_r <= 1'b0;
      write_r <= 1'b0;
    end else if (bit_stb) begin
      if (state_r == psm_pkg::S_HDR && pos_r == psm_pkg::POS_HDR_LAST) begin
        read_r <= addr_match && hdr_is_read;
        write_r <= addr_match && hdr_is_write;
      end else if (state_r == psm_pkg::S_DATA && pos_r == psm_pkg::POS_LAST) begin
        read_r <= 1'b0;
        write_r <= 1'b0;
      end
    end
  end

  // ----------------------------------------------------------------
  // Register bank access
  // ----------------------------------------------------------------
  logic hdr_done;
  logic int_pending;

  assign hdr_done = bit_stb && state_r == psm_pkg::S_HDR && pos_r == psm_pkg::POS_HDR_LAST;
  assign reg_bus.rd = hdr_done && addr_match && hdr_is_read;
  assign reg_bus.wr = bit_stb && state_r == psm_pkg::S_DATA && pos_r == psm_pkg::POS_LAST && write_r;
  assign reg_bus.addr = hdr_done ? hdr_full[psm_pkg::HDR_REG_LSB +: 5] : reg_addr_r;
  assign reg_bus.wdata = {wsh_r[14:0], bit_in};

  psm_reg_bank #(
    .PAGES(PAGES),
    .EXT_DEPTH(EXT_DEPTH)
  ) u_bank (
    .clk(I_CLK),
    .rst_n(I_RESETN),
    .bus(reg_bus),
    .i_int_event(I_INT_EVENT),
    .o_int_pending(int_pending)
  );

  // ----------------------------------------------------------------
  // Data line driver
  // ----------------------------------------------------------------
  logic [15:0] rsh_r;
  logic mdio_o_r;
  logic mdio_oe_r;
  logic drv_start;
  logic drv_stop;
  logic drv_shift;

  assign drv_start = bit_stb && read_r && state_r == psm_pkg::S_TURN && pos_r == psm_pkg::POS_TA1;
  assign drv_stop = bit_stb && read_r && state_r == psm_pkg::S_DATA && pos_r == psm_pkg::POS_LAST;
  assign drv_shift = bit_stb && read_r && !drv_start && !drv_stop &&
                     (state_r == psm_pkg::S_TURN || state_r == psm_pkg::S_DATA);

  // Read data shifter, loaded when the header completes
  always_ff @(posedge I_CLK or negedge I_RESETN) begin
    if (!I_RESETN) begin
      rsh_r <= 16'h0000;
    end else if (reg_bus.rd) begin
      rsh_r <= reg_bus.rdata;
    end else if (drv_shift) begin
      rsh_r <= {rsh_r[14:0], 1'b0};
    end
  end

  // Driven value: turnaround zero, then data, then idle one
  always_ff @(posedge I_CLK or negedge I_RESETN) begin
    if (!I_RESETN) begin
      mdio_o_r <= 1'b1;
    end else if (drv_start) begin
      mdio_o_r <= 1'b0;
    end else if (drv_stop) begin
      mdio_o_r <= 1'b1;
    end else if (drv_shift) begin
      mdio_o_r <= rsh_r[15];
    end
  end

  // Output enable: from second turnaround bit to end of data
  always_ff @(posedge I_CLK or negedge I_RESETN) begin
    if (!I_RESETN) begin
      mdio_oe_r <= 1'b0;
    end else if (drv_start) begin
      mdio_oe_r <= 1'b1;
    end else if (drv_stop) begin
      mdio_oe_r <= 1'b0;
    end
  end

  assign O_MDIO = mdio_o_r;
  assign O_MDIO_OE = mdio_oe_r;

  // ----------------------------------------------------------------
  // Interrupt pin, open drain active low
  // ----------------------------------------------------------------
  logic int_oe_r;

  always_ff @(posedge I_CLK or negedge I_RESETN) begin
    if (!I_RESETN) begin
      int_oe_r <= 1'b0;
    end else begin
      int_oe_r <= int_pending;
    end
  end

  assign O_MGMT_INTERRUPT_N = 1'b0;
  assign O_MGMT_INTERRUPT_N_OE = int_oe_r;

endmodule : psm_mgmt_slave

// *** sim/psm_mgmt_slave_props.sv ***
// Port checker for the serial management slave
`timescale 1ns/1ps
module psm_mgmt_slave_props (
  input wire logic I_CLK,
  input wire logic I_RESETN,
  input wire logic I_MDC,
  input wire logic I_MDIO,
  input wire logic O_MDIO,
  input wire logic O_MDIO_OE,
  input wire logic [4:0] I_PHY_ADDR,
  input wire logic I_INT_EVENT,
  input wire logic O_MGMT_INTERRUPT_N,
  input wire logic O_MGMT_INTERRUPT_N_OE
);
  // ----------------------------------------------------------------
  // Clock rise history and driven-bit count
  // ----------------------------------------------------------------
  logic mdc_r;
  logic [7:0] rise_r;
  logic [4:0] drv_cnt_r;
  always_ff @(posedge I_CLK or negedge I_RESETN) begin
    if (!I_RESETN) begin
      mdc_r <= 1'h0;
      rise_r <= 8'h00;
    end else begin
      mdc_r <= I_MDC;
      rise_r <= {rise_r[6:0], I_MDC & ~mdc_r};
    end
  end
  always_ff @(posedge I_CLK or negedge I_RESETN) begin
    if (!I_RESETN) begin
      drv_cnt_r <= 5'h00;
    end else if (!O_MDIO_OE) begin
      drv_cnt_r <= 5'h00;
    end else if (I_MDC && !mdc_r) begin
      drv_cnt_r <= drv_cnt_r + 5'h01;
    end
  end
  // ----------------------------------------------------------------
  // Properties
  // ----------------------------------------------------------------
  default clocking @(posedge I_CLK); endclocking
  default disable iff (!I_RESETN);
  sequence s_drive_start;
    $rose(O_MDIO_OE) ##0 !O_MDIO;
  endsequence
  sequence s_turn_hold;
    (O_MDIO_OE && !O_MDIO) [*3];
  endsequence
  property p_idle_high;
    !O_MDIO_OE |-> O_MDIO;
  endproperty
  property p_change_on_rise;
    ($changed(O_MDIO) || $changed(O_MDIO_OE)) |-> (|rise_r[6:1]);
  endproperty
  property p_turn_zero;
    $rose(O_MDIO_OE) |-> s_drive_start ##0 s_turn_hold;
  endproperty
  property p_drive_len;
    $fell(O_MDIO_OE) |-> drv_cnt_r == 5'h11;
  endproperty
  property p_quiet_after_reset;
    $rose(I_RESETN) |-> !O_MDIO_OE && !O_MGMT_INTERRUPT_N_OE;
  endproperty
  property p_int_low;
    O_MGMT_INTERRUPT_N_OE |-> !O_MGMT_INTERRUPT_N;
  endproperty
  property p_int_rise;
    $rose(O_MGMT_INTERRUPT_N_OE) |-> $past(I_INT_EVENT, 2) || (|rise_r);
  endproperty
  property p_int_fall;
    $fell(O_MGMT_INTERRUPT_N_OE) |-> (|rise_r);
  endproperty
  a_idle_high: assert property (p_idle_high) else $error("data line not high while released");
  a_change_on_rise: assert property (p_change_on_rise) else $error("data out moved without clock rise");
  a_turn_zero: assert property (p_turn_zero) else $error("turnaround bit not driven zero");
  a_drive_len: assert property (p_drive_len) else $error("wrong number of driven bits");
  a_quiet_after_reset: assert property (p_quiet_after_reset) else $error("outputs driven after reset");
  a_int_low: assert property (p_int_low) else $error("interrupt pin not low when on");
  a_int_rise: assert property (p_int_rise) else $error("interrupt pin without cause");
  a_int_fall: assert property (p_int_fall) else $error("interrupt pin released without access");
endmodule : psm_mgmt_slave_props

// *** sim/psm_mgr_model.sv ***
// Station manager model driving the management clock and data line
`timescale 1ns/1ps
module psm_mgr_model (
  input wire logic clk,
  input wire logic dev_mdio,
  input wire logic dev_oe,
  output logic mdc,
  output logic mdio
);
  logic mdo;
  logic mdo_oe;
  // Wire level: device, else manager, else the pull-up
  assign mdio = dev_oe ? dev_mdio : (mdo_oe ? mdo : 1'h1);
  initial begin
    mdc = 1'h0;
    mdo = 1'h1;
    mdo_oe = 1'h0;
  end
  // One bit: set while clock low, sampled at rise, held 3 cycles after
  task automatic bit_cycle(input logic b, input logic drv, output logic s);
    @(posedge clk);
    #1;
    mdc = 1'h0;
    mdo = b;
    mdo_oe = drv;
    repeat (4) @(posedge clk);
    #1;
    s = mdio;
    mdc = 1'h1;
    repeat (3) @(posedge clk);
  endtask : bit_cycle
  // Whole frame after npre preamble ones; released from the first turnaround on reads
  task automatic frame(input logic [31:0] f, input logic rd, input int npre, output logic [15:0] q,
    output logic [1:0] ta);
    logic s;
    for (int i = 0; i < npre; i++) bit_cycle(1'h1, 1'h1, s);
    for (int i = 31; i >= 0; i--) begin
      bit_cycle(f[i], !(rd && i < 18), s);
      if (i == 17 || i == 16) ta = {ta[0], s};
      if (i < 16) q = {q[14:0], s};
    end
    @(posedge clk);
    #1;
    mdc = 1'h0;
    mdo_oe = 1'h0;
  endtask : frame
endmodule : psm_mgr_model

// *** sim/psm_mgmt_slave_tb.sv ***
// Testbench for the serial management slave
`timescale 1ns/1ps
module psm_mgmt_slave_tb;
  localparam logic [4:0] OWN_ADDR = 5'h0B;
  logic clk = 1'h0;
  logic rst_n;
  logic mdc;
  logic mdio;
  logic o_mdio;
  logic o_mdio_oe;
  logic int_event;
  logic int_n;
  logic int_n_oe;
  logic [15:0] q;
  logic [1:0] ta;
  int miscompares;
  int comparisons;
  int npre;
  always #10 clk = ~clk;
  psm_mgmt_slave #(.PAGES(2), .EXT_DEPTH(8)) psm_mgmt_slave_inst (.I_CLK(clk), .I_RESETN(rst_n), .I_MDC(mdc),
    .I_MDIO(mdio), .O_MDIO(o_mdio), .O_MDIO_OE(o_mdio_oe), .I_PHY_ADDR(OWN_ADDR), .I_INT_EVENT(int_event),
    .O_MGMT_INTERRUPT_N(int_n), .O_MGMT_INTERRUPT_N_OE(int_n_oe));
  psm_mgr_model psm_mgr_model_inst (.clk(clk), .dev_mdio(o_mdio), .dev_oe(o_mdio_oe), .mdc(mdc), .mdio(mdio));
  // ----------------------------------------------------------------
  // Shared tasks
  // ----------------------------------------------------------------
  task automatic wrap_up();
    $display("comparisons %0d miscompares %0d", comparisons, miscompares);
    if (miscompares == 0 && comparisons > 0) begin
      $display("DONE - PASS");
    end else begin
      $display("DONE - FAIL");
    end
    $finish;
  endtask : wrap_up
  task automatic chk(input logic [15:0] got, input logic [15:0] exp);
    comparisons++;
    if (got !== exp) begin
      miscompares++;
      $display("mismatch at %0t: got %h expected %h", $time, got, exp);
    end
  endtask : chk
  task automatic xfer(input logic [1:0] st, input logic [1:0] op, input logic [4:0] pa, input logic [4:0] ra,
    input logic [15:0] d);
    psm_mgr_model_inst.frame({st, op, pa, ra, 2'h2, d}, op == 2'h2, npre, q, ta);
  endtask : xfer
  task automatic wr(input logic [4:0] ra, input logic [15:0] d);
    xfer(2'h1, 2'h1, OWN_ADDR, ra, d);
  endtask : wr
  task automatic rd(input logic [4:0] ra, input logic [15:0] exp);
    xfer(2'h1, 2'h2, OWN_ADDR, ra, 16'h0000);
    chk({14'h0000, ta}, 16'h0002);
    chk(q, exp);
  endtask : rd
  task automatic pulse_event();
    @(posedge clk);
    #1;
    int_event = 1'h1;
    @(posedge clk);
    #1;
    int_event = 1'h0;
    repeat (3) @(posedge clk);
  endtask : pulse_event
  // ----------------------------------------------------------------
  // Scenarios
  // ----------------------------------------------------------------
  task automatic t_basic();
    wr(5'h10, 16'hA5C3);
    wr(5'h00, 16'h8001);
    rd(5'h10, 16'hA5C3);
    rd(5'h00, 16'h8001);
  endtask : t_basic
  task automatic t_no_pre();
    npre = 0;
    wr(5'h11, 16'h5AA5);
    rd(5'h11, 16'h5AA5);
    npre = 2;
  endtask : t_no_pre
  task automatic t_foreign();
    xfer(2'h1, 2'h1, OWN_ADDR ^ 5'h01, 5'h10, 16'h3C3C);
    xfer(2'h1, 2'h2, OWN_ADDR ^ 5'h10, 5'h10, 16'h0000);
    chk(q, 16'hFFFF);
    chk({14'h0000, ta}, 16'h0003);
    rd(5'h10, 16'hA5C3);
  endtask : t_foreign
  task automatic t_bad_frames();
    logic [3:0] v [3] = '{4'h1, 4'h7, 4'h4};
    foreach (v[i]) xfer(v[i][3:2], v[i][1:0], OWN_ADDR, 5'h10, 16'h1234);
    rd(5'h10, 16'hA5C3);
  endtask : t_bad_frames
  task automatic t_pages();
    wr(5'h1F, 16'h0001);
    wr(5'h10, 16'h1111);
    rd(5'h10, 16'h1111);
    rd(5'h1F, 16'h0001);
    wr(5'h1F, 16'h0002);
    rd(5'h10, 16'h0000);
    wr(5'h1F, 16'h0000);
    rd(5'h10, 16'hA5C3);
  endtask : t_pages
  task automatic t_ext();
    wr(5'h0D, 16'h0000);
    wr(5'h0E, 16'h0003);
    wr(5'h0D, 16'h4000);
    wr(5'h0E, 16'hBEEF);
    wr(5'h0D, 16'h0000);
    rd(5'h0E, 16'h0003);
    wr(5'h0D, 16'h4000);
    rd(5'h0E, 16'hBEEF);
  endtask : t_ext
  task automatic t_int();
    wr(5'h19, 16'h8000);
    pulse_event();
    chk({14'h0000, int_n_oe, int_n}, 16'h0002);
    rd(5'h1A, 16'h8000);
    chk({15'h0000, int_n_oe}, 16'h0000);
    wr(5'h19, 16'h0000);
    pulse_event();
    chk({15'h0000, int_n_oe}, 16'h0000);
    rd(5'h1A, 16'h8000);
  endtask : t_int
  // ----------------------------------------------------------------
  // Main sequence and watchdog
  // ----------------------------------------------------------------
  initial begin
    rst_n = 1'h0;
    int_event = 1'h0;
    miscompares = 0;
    comparisons = 0;
    npre = 2;
    repeat (4) @(posedge clk);
    #1;
    rst_n = 1'h1;
    repeat (4) @(posedge clk);
    t_basic();
    t_no_pre();
    t_foreign();
    t_bad_frames();
    t_pages();
    t_ext();
    t_int();
    wrap_up();
  end
  initial begin
    repeat (40000) @(posedge clk);
    miscompares++;
    wrap_up();
  end
endmodule : psm_mgmt_slave_tb
bind psm_mgmt_slave psm_mgmt_slave_props psm_mgmt_slave_props_inst (.I_CLK(I_CLK), .I_RESETN(I_RESETN),
  .I_MDC(I_MDC), .I_MDIO(I_MDIO), .O_MDIO(O_MDIO), .O_MDIO_OE(O_MDIO_OE), .I_PHY_ADDR(I_PHY_ADDR),
  .I_INT_EVENT(I_INT_EVENT), .O_MGMT_INTERRUPT_N(O_MGMT_INTERRUPT_N), .O_MGMT_INTERRUPT_N_OE(O_MGMT_INTERRUPT_N_OE));
